// file: core/timer_ctrl_defs.svh
// offsets, field positions and codes of the timer and flag control block
`ifndef TIMER_CTRL_DEFS_SVH
`define TIMER_CTRL_DEFS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_FLAGS 8'h04
`define OFS_WAKE 8'h08
`define OFS_TIMERS 8'h0C
// ----------------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------------
`define CMD_OP_HI 15
`define CMD_OP_LO 12
`define CMD_X_HI 8
// ----------------------------------------------------------------------
// flag register bit positions
// ----------------------------------------------------------------------
`define FLG_CARRY 0
`define FLG_BACKUP 1
`define FLG_EL 2
`define FLG_WDOG 3
`define FLG_RELOAD1 4
`define FLG_LCD_BLANK 5
`define FLG_INT_PULL 6
`define FLG_DED 7
`define FLG_RELOAD2 8
`define FLG_W 9
`define FLG_RST 9'h000
// ----------------------------------------------------------------------
// wake flag positions
// ----------------------------------------------------------------------
`define WK_PORT_C 0
`define WK_TIMER1 1
`define WK_INT 2
`define WK_PRESCALER 3
`define WK_TIMER2 4
`define WK_KEY 5
`define WK_RFC 6
`define WK_W 7
`define WK_RST 7'h00
// ----------------------------------------------------------------------
// prescaler and clock sources
// ----------------------------------------------------------------------
`define PRE_W 15
`define PRE_CLR_W 5
`define TAP_THREE 2
`define TAP_FIVE 4
`define TAP_SEVEN 6
`define TAP_NINE 8
`define TAP_ELEVEN 10
`define TAP_THIRTEEN 12
`define TAP_FIFTEEN 14
`define SEL_TAP9 3'h0
`define SEL_TAP3 3'h1
`define SEL_TAP15 3'h2
`define SEL_TONE 3'h3
`define SEL_TAP5 3'h4
`define SEL_TAP7 3'h5
`define SEL_TAP11 3'h6
`define SEL_TAP13 3'h7
`define TMR_W 6
`endif

// file: core/timer_ctrl_pkg.sv
// types shared by the timer and flag control block
`default_nettype none
package timer_ctrl_pkg;
    typedef enum logic [3:0] {
        OP_TMS_RX = 4'h0,
        OP_TMS_TBL = 4'h1,
        OP_TMS_IMM = 4'h2,
        OP_TM2_RX = 4'h3,
        OP_TM2_TBL = 4'h4,
        OP_TM2_IMM = 4'h5,
        OP_SF = 4'h6,
        OP_RF = 4'h7,
        OP_SF2 = 4'h8,
        OP_RF2 = 4'h9,
        OP_PLC = 4'hA
    } op_e;
endpackage
`default_nettype wire

// file: core/prescaler_chain.sv
// fifteen-bit free running prescaler with partial clear
`include "timer_ctrl_defs.svh"
`default_nettype none
module prescaler_chain (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_low_i,
    output logic [`PRE_W-1:0] count_o,
    output logic overflow_o
);
    logic [`PRE_W-1:0] count_r;
    logic ovf_r;
    logic [`PRE_W-1:0] count_inc;
    logic [`PRE_W-1:0] count_nxt;

    assign count_inc = count_r + 15'h0001;
    assign count_nxt = clear_low_i
        ? {count_inc[`PRE_W-1:`PRE_CLR_W], {`PRE_CLR_W{1'b0}}}
        : count_inc;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_r <= 15'h0000;
            ovf_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            ovf_r <= &count_r;
        end
    end

    assign count_o = count_r;
    assign overflow_o = ovf_r;

    property p_pre_clear;
        @(posedge clk_i) disable iff (rst_i)
        clear_low_i |=> (count_o[`PRE_CLR_W-1:0] == 5'h00);
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler low bits not cleared");
endmodule
`default_nettype wire

// file: core/timer_channel.sv
// six-bit down timer with selectable clock source and reload
`include "timer_ctrl_defs.svh"
`default_nettype none
module timer_channel (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [2:0] sel_i,
    input wire logic [`TMR_W-1:0] preset_i,
    input wire logic stop_i,
    input wire logic reload_en_i,
    input wire logic [`PRE_W-1:0] taps_i,
    input wire logic tone_i,
    output logic [`TMR_W-1:0] count_o,
    output logic running_o,
    output logic underflow_o
);
    logic [2:0] sel_r;
    logic [`TMR_W-1:0] preset_r;
    logic [`TMR_W-1:0] count_r;
    logic run_r;
    logic src_d_r;
    logic uf_r;
    logic src;
    logic tick;
    logic uf_now;

    assign src = (sel_r == `SEL_TAP9) ? taps_i[`TAP_NINE] :
                 (sel_r == `SEL_TAP3) ? taps_i[`TAP_THREE] :
                 (sel_r == `SEL_TAP15) ? taps_i[`TAP_FIFTEEN] :
                 (sel_r == `SEL_TONE) ? tone_i :
                 (sel_r == `SEL_TAP5) ? taps_i[`TAP_FIVE] :
                 (sel_r == `SEL_TAP7) ? taps_i[`TAP_SEVEN] :
                 (sel_r == `SEL_TAP11) ? taps_i[`TAP_ELEVEN] :
                 taps_i[`TAP_THIRTEEN];
    // rising edge only, so a slow source counts once per period
    assign tick = src & ~src_d_r & run_r;
    assign uf_now = tick & (count_r == 6'h00);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel_r <= 3'h0;
            preset_r <= 6'h00;
            count_r <= 6'h00;
            run_r <= 1'b0;
            src_d_r <= 1'b0;
            uf_r <= 1'b0;
        end
        else
        begin
            src_d_r <= src | load_i; // a new select must not read as a source edge
            uf_r <= uf_now & ~load_i & ~stop_i;
            if (load_i)
            begin
                sel_r <= sel_i;
                preset_r <= preset_i;
                count_r <= preset_i;
                run_r <= 1'b1;
            end
            else if (stop_i)
                run_r <= 1'b0;
            else if (uf_now)
            begin
                count_r <= preset_r;
                run_r <= reload_en_i;
            end
            else if (tick)
                count_r <= count_r - 6'h01;
        end
    end

    assign count_o = count_r;
    assign running_o = run_r;
    assign underflow_o = uf_r;

    property p_load;
        @(posedge clk_i) disable iff (rst_i)
        load_i |=> (count_o == $past(preset_i)) && running_o;
    endproperty
    a_load: assert property (p_load) else $error("timer did not start from preset");
    property p_stop;
        @(posedge clk_i) disable iff (rst_i)
        (stop_i && !load_i) |=> !running_o;
    endproperty
    a_stop: assert property (p_stop) else $error("timer kept running after stop");
endmodule
`default_nettype wire

// file: core/timer_load_and_flag_control.sv
// instruction driven timer loading and system flag control
// ----------------------------------------------------------------------
// Summary of operation
// - register timer-one load: select from acc[3:2], preset acc[1:0] plus nibble
// - two-bit select: 00 tap9, 01 tap3, 10 tap15, 11 tone output
// - table timer-one load: byte bits 7..6 select, bits 5..0 preset
// - immediate timer-one load: operand bits 8..6 select, bits 5..0 preset
// - three-bit select: 100..111 pick taps five, seven, eleven, thirteen
// - register timer-two load uses accumulator and nibble like timer one
// - table timer-two load: byte bits 7..6 select, bits 5..0 preset
// - immediate timer-two load uses the eight-source select mapping
// - operand bit 0 sets or clears the carry flag
// - operand bit 1 enters or leaves backup mode with its flag
// - operand bit 2 turns the panel driver on or off
// - set with bits 2 and 3 drives panel and requests halt
// - operand bit 4 starts or disables the watchdog with its flag
// - operand bit 7 enables or disables timer-one reload; 5, 6 ignored
// - second set/reset bit 3 switches the strong interrupt pull-down
// - second set/reset bit 2 blanks or restores the display
// - second set/reset bit 1 sets or clears display-enable-detect
// - second set/reset bit 0 switches timer-two reload
// - pulse clears wake flags for port c, int, prescaler, key, converter
// - pulse bit 1 or 4 clears timer wake flag and stops timer
// - pulse bit 8 clears the low five prescaler bits
// ----------------------------------------------------------------------
`include "timer_ctrl_defs.svh"
`default_nettype none
module timer_load_and_flag_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [3:0] accumulator_i,
    input wire logic [3:0] addressed_nibble_i,
    input wire logic [7:0] index_pointer_byte_i,
    input wire logic tone_generator_output_i,
    input wire logic port_c_event_i,
    input wire logic int_pin_event_i,
    input wire logic key_input_event_i,
    input wire logic rfc_overflow_i,
    output logic carry_flag_o,
    output logic backup_flag_o,
    output logic el_driver_o,
    output logic watchdog_flag_o,
    output logic lcd_blank_o,
    output logic int_strong_pull_o,
    output logic display_enable_detect_flag_o,
    output logic halt_request_o,
    output logic [`WK_W-1:0] wake_flags_o
);
    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    logic ack_r;
    logic [31:0] dat_r;
    logic [15:0] cmd_r;
    logic req;
    logic hit_cmd;
    logic exec;
    logic [31:0] rd_word;

    assign req = cyc_i & stb_i;
    assign hit_cmd = (adr_i == `OFS_CMD);
    // commands need the low half-word lanes; partial writes are dropped
    assign exec = req & we_i & ack_r & hit_cmd & (&sel_i[1:0]);

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic [3:0] op;
    logic [`CMD_X_HI:0] x;
    logic src_rx;
    logic src_tbl;
    logic t1_load;
    logic t2_load;
    logic [2:0] ld_sel;
    logic [`TMR_W-1:0] ld_preset;
    logic sf;
    logic rf;
    logic sf2;
    logic rf2;
    logic pulse_control_op;

    assign op = dat_i[`CMD_OP_HI:`CMD_OP_LO];
    assign x = dat_i[`CMD_X_HI:0];
    assign sf = exec & (op == timer_ctrl_pkg::OP_SF);
    assign rf = exec & (op == timer_ctrl_pkg::OP_RF);
    assign sf2 = exec & (op == timer_ctrl_pkg::OP_SF2);
    assign rf2 = exec & (op == timer_ctrl_pkg::OP_RF2);
    assign pulse_control_op = exec & (op == timer_ctrl_pkg::OP_PLC);
    assign src_rx = (op == timer_ctrl_pkg::OP_TMS_RX) | (op == timer_ctrl_pkg::OP_TM2_RX);
    assign src_tbl = (op == timer_ctrl_pkg::OP_TMS_TBL) | (op == timer_ctrl_pkg::OP_TM2_TBL);
    assign t1_load = exec & ((op == timer_ctrl_pkg::OP_TMS_RX)
        | (op == timer_ctrl_pkg::OP_TMS_TBL) | (op == timer_ctrl_pkg::OP_TMS_IMM));
    assign t2_load = exec & ((op == timer_ctrl_pkg::OP_TM2_RX)
        | (op == timer_ctrl_pkg::OP_TM2_TBL) | (op == timer_ctrl_pkg::OP_TM2_IMM));
    // two-bit selects widen with a zero so they share the eight-way map
    assign ld_sel = src_rx ? {1'b0, accumulator_i[3:2]} :
                    src_tbl ? {1'b0, index_pointer_byte_i[7:6]} :
                    x[8:6];
    assign ld_preset = src_rx ? {accumulator_i[1:0], addressed_nibble_i} :
                       src_tbl ? index_pointer_byte_i[5:0] :
                       x[5:0];

    // ------------------------------------------------------------------
    // system flags
    // ------------------------------------------------------------------
    logic [`FLG_W-1:0] flags_r;
    logic [`FLG_W-1:0] flags_nxt;
    logic [`FLG_W-1:0] set_vec;
    logic [`FLG_W-1:0] clr_vec;
    logic halt_r;

    assign set_vec[`FLG_CARRY] = sf & x[0];
    assign clr_vec[`FLG_CARRY] = rf & x[0];
    assign set_vec[`FLG_BACKUP] = sf & x[1];
    assign clr_vec[`FLG_BACKUP] = rf & x[1];
    assign set_vec[`FLG_EL] = sf & x[2];
    assign clr_vec[`FLG_EL] = rf & x[2];
    assign set_vec[`FLG_WDOG] = sf & x[4];
    assign clr_vec[`FLG_WDOG] = rf & x[4];
    assign set_vec[`FLG_RELOAD1] = sf & x[7];
    assign clr_vec[`FLG_RELOAD1] = rf & x[7];
    assign set_vec[`FLG_INT_PULL] = sf2 & x[3];
    assign clr_vec[`FLG_INT_PULL] = rf2 & x[3];
    assign set_vec[`FLG_LCD_BLANK] = sf2 & x[2];
    assign clr_vec[`FLG_LCD_BLANK] = rf2 & x[2];
    assign set_vec[`FLG_DED] = sf2 & x[1];
    assign clr_vec[`FLG_DED] = rf2 & x[1];
    assign set_vec[`FLG_RELOAD2] = sf2 & x[0];
    assign clr_vec[`FLG_RELOAD2] = rf2 & x[0];
    assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_r <= `FLG_RST;
            halt_r <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            halt_r <= sf & x[2] & x[3];
        end
    end

    // ------------------------------------------------------------------
    // prescaler and timers
    // ------------------------------------------------------------------
    logic [`PRE_W-1:0] pre_count;
    logic pre_ovf;
    logic [`TMR_W-1:0] t1_count;
    logic [`TMR_W-1:0] t2_count;
    logic t1_run;
    logic t2_run;
    logic t1_uf;
    logic t2_uf;

    // clear request is honoured alone; pairing it with bit 3 is software's job
    prescaler_chain u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_low_i(pulse_control_op & x[8]),
        .count_o(pre_count),
        .overflow_o(pre_ovf)
    );

    timer_channel u_t1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(t1_load),
        .sel_i(ld_sel),
        .preset_i(ld_preset),
        .stop_i(pulse_control_op & x[1]),
        .reload_en_i(flags_r[`FLG_RELOAD1]),
        .taps_i(pre_count),
        .tone_i(tone_generator_output_i),
        .count_o(t1_count),
        .running_o(t1_run),
        .underflow_o(t1_uf)
    );

    timer_channel u_t2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(t2_load),
        .sel_i(ld_sel),
        .preset_i(ld_preset),
        .stop_i(pulse_control_op & x[4]),
        .reload_en_i(flags_r[`FLG_RELOAD2]),
        .taps_i(pre_count),
        .tone_i(tone_generator_output_i),
        .count_o(t2_count),
        .running_o(t2_run),
        .underflow_o(t2_uf)
    );

    // ------------------------------------------------------------------
    // halt release flags
    // ------------------------------------------------------------------
    logic [`WK_W-1:0] wake_r;
    logic [`WK_W-1:0] wake_set;
    logic [`WK_W-1:0] wake_clr;

    assign wake_set[`WK_PORT_C] = port_c_event_i;
    assign wake_set[`WK_TIMER1] = t1_uf;
    assign wake_set[`WK_INT] = int_pin_event_i;
    assign wake_set[`WK_PRESCALER] = pre_ovf;
    assign wake_set[`WK_TIMER2] = t2_uf;
    assign wake_set[`WK_KEY] = key_input_event_i;
    assign wake_set[`WK_RFC] = rfc_overflow_i;
    assign wake_clr = {`WK_W{pulse_control_op}} & x[`WK_W-1:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wake_r <= `WK_RST;
        else
            wake_r <= (wake_r & ~wake_clr) | wake_set; // set wins over clear
    end

    // ------------------------------------------------------------------
    // register read and acknowledge
    // ------------------------------------------------------------------
    assign rd_word = (adr_i == `OFS_CMD) ? {16'h0000, cmd_r} :
                     (adr_i == `OFS_FLAGS) ? {23'h000000, flags_r} :
                     (adr_i == `OFS_WAKE) ? {25'h0000000, wake_r} :
                     (adr_i == `OFS_TIMERS) ? {16'h0000, t2_run, 1'b0, t2_count,
                                               t1_run, 1'b0, t1_count} :
                     32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
            cmd_r <= 16'h0000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            dat_r <= rd_word;
            if (exec)
                cmd_r <= dat_i[15:0];
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign carry_flag_o = flags_r[`FLG_CARRY];
    assign backup_flag_o = flags_r[`FLG_BACKUP];
    assign el_driver_o = flags_r[`FLG_EL];
    assign watchdog_flag_o = flags_r[`FLG_WDOG];
    assign lcd_blank_o = flags_r[`FLG_LCD_BLANK];
    assign int_strong_pull_o = flags_r[`FLG_INT_PULL];
    assign display_enable_detect_flag_o = flags_r[`FLG_DED];
    assign halt_request_o = halt_r;
    assign wake_flags_o = wake_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_halt_pulse;
        halt_request_o ##1 !halt_request_o;
    endsequence
    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence

    property p_ack;
        (req && !ack_o) |=> s_ack_pulse;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a single cycle pulse");
    property p_carry_set;
        (sf && x[0]) |=> carry_flag_o;
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry not set");
    property p_carry_clr;
        (rf && x[0]) |=> !carry_flag_o;
    endproperty
    a_carry_clr: assert property (p_carry_clr) else $error("carry not cleared");
    property p_backup;
        (sf && x[1]) |=> backup_flag_o;
    endproperty
    a_backup: assert property (p_backup) else $error("backup flag not set");
    property p_el_off;
        (rf && x[2]) |=> !el_driver_o;
    endproperty
    a_el_off: assert property (p_el_off) else $error("panel driver still on");
    property p_halt;
        (sf && x[2] && x[3]) |=> el_driver_o and s_halt_pulse;
    endproperty
    a_halt: assert property (p_halt) else $error("halt request missing");
    property p_wdog;
        (rf && x[4]) |=> !watchdog_flag_o;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog flag not cleared");
    property p_pull;
        (sf2 && x[3]) |=> int_strong_pull_o;
    endproperty
    a_pull: assert property (p_pull) else $error("strong pull-down not on");
    property p_blank;
        (rf2 && x[2]) |=> !lcd_blank_o;
    endproperty
    a_blank: assert property (p_blank) else $error("display not restored");
    property p_ded;
        (sf2 && x[1]) |=> display_enable_detect_flag_o;
    endproperty
    a_ded: assert property (p_ded) else $error("detect flag not set");
    property p_wake_clr;
        (pulse_control_op && x[0] && !port_c_event_i) |=> !wake_flags_o[`WK_PORT_C];
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("port c wake flag kept");
    property p_wake_win;
        (pulse_control_op && x[`WK_KEY] && key_input_event_i) |=> wake_flags_o[`WK_KEY];
    endproperty
    a_wake_win: assert property (p_wake_win) else $error("key wake event lost");
    property p_backup_clr;
        (rf && x[1]) |=> !backup_flag_o;
    endproperty
    a_backup_clr: assert property (p_backup_clr) else $error("backup flag not cleared");
    property p_wdog_set;
        (sf && x[4]) |=> watchdog_flag_o;
    endproperty
    a_wdog_set: assert property (p_wdog_set) else $error("watchdog flag not set");
    property p_reload2_clr;
        (rf2 && x[0]) |=> !flags_r[`FLG_RELOAD2];
    endproperty
    a_reload2_clr: assert property (p_reload2_clr) else $error("timer two reload kept");
    property p_t2_wake_clr;
        (pulse_control_op && x[`WK_TIMER2] && !t2_uf) |=> !wake_flags_o[`WK_TIMER2];
    endproperty
    a_t2_wake_clr: assert property (p_t2_wake_clr) else $error("timer two wake kept");
endmodule
`default_nettype wire

// file: verification/core_side_model.sv
// processor core side: operand sources, tone source and event lines
`default_nettype none
module core_side_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] src_i,
    input wire logic [3:0] ev_i,
    output logic [15:0] src_o,
    output logic [3:0] ev_o,
    output logic tone_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_r;
    // operands settle a cycle before the command word executes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ph_r <= 2'h0;
        else
            ph_r <= ph_r + 2'h1;
        src_o <= src_i;
        ev_o <= ev_i;
    end
    // tone runs free with a period of four cycles
    assign tone_o = ph_r[1];
endmodule
`default_nettype wire

// file: verification/tb.sv
// self-checking bench of the timer and flag control block
`include "timer_ctrl_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cyc, stb, we, ack, halt, cy, bk, el, wd, lb, ip, ded, tone;
    logic [3:0] sel, ev, evq;
    logic [6:0] wake, mw;
    logic [7:0] adr, r;
    logic [8:0] mf;
    logic [15:0] src, srcq, last;
    logic [31:0] wdat, rdat, rd, c0;
    int mismatches = 0, samples_checked = 0, cycles = 0, sh;
    int per[8] = '{512, 8, 0, 4, 32, 128, 2048, 8192};
    int wb[4] = '{0, 2, 5, 6};
    logic [3:0] fo[4] = '{timer_ctrl_pkg::OP_SF, timer_ctrl_pkg::OP_RF,
        timer_ctrl_pkg::OP_SF2, timer_ctrl_pkg::OP_RF2};
    logic [3:0] lo[6] = '{timer_ctrl_pkg::OP_TMS_RX, timer_ctrl_pkg::OP_TMS_TBL,
        timer_ctrl_pkg::OP_TMS_IMM, timer_ctrl_pkg::OP_TM2_RX,
        timer_ctrl_pkg::OP_TM2_TBL, timer_ctrl_pkg::OP_TM2_IMM};
    wire [7:0] pins = {halt, ded, ip, lb, wd, el, bk, cy};
    core_side_model core (.clk_i(clk), .rst_i(rst), .src_i(src), .ev_i(ev),
        .src_o(srcq), .ev_o(evq), .tone_o(tone));
    timer_load_and_flag_control uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
        .ack_o(ack), .accumulator_i(srcq[7:4]), .addressed_nibble_i(srcq[3:0]),
        .index_pointer_byte_i(srcq[15:8]), .tone_generator_output_i(tone),
        .port_c_event_i(evq[0]), .int_pin_event_i(evq[1]), .key_input_event_i(evq[2]),
        .rfc_overflow_i(evq[3]), .carry_flag_o(cy), .backup_flag_o(bk),
        .el_driver_o(el), .watchdog_flag_o(wd), .lcd_blank_o(lb),
        .int_strong_pull_o(ip), .display_enable_detect_flag_o(ded),
        .halt_request_o(halt), .wake_flags_o(wake));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, well above the longest rate check
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp, input string m);
        chk_word({24'h0, got}, {24'h0, exp}, m);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk_word(32'(n), 32'h2, "ack delay");
    endtask
    task automatic cmd(input logic [3:0] op, input logic [8:0] x);
        last = {op, 3'h0, x};
        bus(1'b1, `OFS_CMD, {16'h0, last}, 4'hF);
    endtask
    task automatic wait_wake(input int b);
        for (int n = 0; n < 200 && wake[b] !== 1'b1; n++)
            @(posedge clk);
        chk_pin({7'h0, wake[b]}, 8'h1, "underflow flag");
    endtask
    // ----
    // scenarios
    // ----
    initial
    begin
        {cyc, stb, we, adr, sel, wdat, src, ev, mf, last} = '0;
        rst = 1'b1;
        void'($urandom(97));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 5; a++)
        begin
            bus(1'b0, 8'(4 * a), 32'h0, 4'hF);
            chk_word(rd, 32'h0, "reset read");
        end
        chk_pin(pins | {1'b0, wake}, 8'h0, "reset pins");
        $display("test reset done");
        // first four commands drive every operand bit, then random mixes
        for (int k = 0; k < 28; k++)
        begin
            int i;
            logic [8:0] x, m;
            i = k < 4 ? k : $urandom % 4;
            x = k < 4 ? 9'h1FF : 9'($urandom);
            m = i[1] ? {x[0], x[1], x[3], x[2], 5'h00} : {4'h0, x[7], x[4], x[2:0]};
            mf = i[0] ? mf & ~m : mf | m;
            cmd(fo[i], x);
            #1 chk_pin(pins, {i == 0 && x[3:2] == 2'b11, mf[7:5], mf[3:0]}, "flags");
            bus(1'b0, `OFS_FLAGS, 32'h0, 4'hF);
            chk_word(rd, {23'h0, mf}, "flag word");
        end
        bus(1'b1, `OFS_CMD, {16'h0, timer_ctrl_pkg::OP_SF, 12'h1FF}, 4'hC);
        bus(1'b1, 8'h10, 32'hFFFF, 4'hF);
        bus(1'b0, 8'h10, 32'h0, 4'hF);
        chk_word(rd, 32'h0, "unmapped");
        bus(1'b0, `OFS_CMD, 32'h0, 4'hF);
        chk_word(rd, {16'h0, last}, "lanes");
        chk_pin(pins, {1'b0, mf[7:5], mf[3:0]}, "lanes");
        $display("test flags done");
        // slow tap keeps the count still between load and read
        for (int k = 0; k < 6; k++)
        begin
            r = 8'($urandom % 64);
            src <= {2'b10, r[5:0], 2'b10, r[5:0]};
            cmd(lo[k], {3'b010, r[5:0]});
            bus(1'b0, `OFS_TIMERS, 32'h0, 4'hF);
            chk_word(rd >> (k / 3 * 8) & 32'hBF, {24'h0, 2'b10, r[5:0]}, "load");
        end
        $display("test loads done");
        @(posedge clk);
        ev <= 4'hF;
        @(posedge clk);
        ev <= 4'h0;
        bus(1'b0, `OFS_WAKE, 32'h0, 4'hF);
        chk_word(rd, 32'h65, "wake set");
        mw = 7'h65;
        foreach (wb[j])
        begin
            mw[wb[j]] = 1'b0;
            cmd(timer_ctrl_pkg::OP_PLC, 9'(1 << wb[j]));
            #1 chk_pin({1'b0, wake}, {1'b0, mw}, "wake clear");
        end
        // key held through its own clear: the event must win
        @(posedge clk);
        ev <= 4'h4;
        cmd(timer_ctrl_pkg::OP_PLC, 9'h020);
        ev <= 4'h0;
        #1 chk_pin({7'h0, wake[5]}, 8'h1, "set wins");
        $display("test wake done");
        // two source periods between equal reads give exactly two steps
        for (int k = 0; k < 16; k++)
        begin
            if (k % 8 == 2)
                continue;
            sh = k / 8 * 8;
            cmd(lo[k / 8 * 3 + 2], {3'(k), 6'h3F});
            bus(1'b0, `OFS_TIMERS, 32'h0, 4'hF);
            c0 = rd;
            repeat (2 * per[k % 8] - 3) @(posedge clk);
            bus(1'b0, `OFS_TIMERS, 32'h0, 4'hF);
            chk_word((c0 >> sh & 32'h3F) - (rd >> sh & 32'h3F), 32'h2, "rate");
        end
        $display("test rates done");
        for (int t = 0; t < 2; t++)
        begin
            int b;
            b = t ? 4 : 1;
            for (int e = 0; e < 2; e++)
            begin
                cmd(timer_ctrl_pkg::OP_PLC, 9'(1 << b));
                cmd(fo[2 * t + 1 - e], t ? 9'h001 : 9'h080);
                cmd(lo[3 * t + 2], 9'h0C1);
                wait_wake(b);
                bus(1'b0, `OFS_TIMERS, 32'h0, 4'hF);
                chk_word(rd >> (8 * t) & (e ? 32'h80 : 32'hBF), e ? 32'h80 : 32'h01, "underflow");
            end
            // a reload underflow may land on the stop; the second pulse clears
            cmd(timer_ctrl_pkg::OP_PLC, 9'(1 << b));
            cmd(timer_ctrl_pkg::OP_PLC, 9'(1 << b));
            bus(1'b0, `OFS_TIMERS, 32'h0, 4'hF);
            chk_word((rd >> (8 * t) & 32'h80) | 32'(wake[b]), 32'h0, "stop");
        end
        $display("test underflow done");
        chk_pin({7'h0, wake[3]}, 8'h1, "overflow");
        cmd(timer_ctrl_pkg::OP_PLC, 9'h108);
        #1 chk_pin({7'h0, wake[3]}, 8'h0, "overflow clear");
        $display("test prescaler done");
        final_report();
    end
endmodule
`default_nettype wire
